// file: hw/sdc_config_latches.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdc_cfg.svh"

// What this block does
// - Output select codes 000/100/010/110 pick analog or digital lock indications.
// - Select codes with last bit set pick one of four divider outputs.
// - Select field 10 copies the whole shifted word into RF reference latch.
// - Bit 23 picks slow or fast delay-line calibration; host normally writes one.
// - Bit 22 of RF reference latch switches the pump-supply voltage doubler.
// - Four pump bits give current of 100 uA plus 100 uA per unit.
// - Select field 01 loads the IF main-divider latch.
// - IF divider: swallow count bits 2-4, main count bits 5-16.
// - Outside quick-settle, bits 17 and 18 set the two general pin levels.
// - Bit 19 low enables spur compensation; host normally keeps it low.
// - Quick-settle: pin 0 pulls low while RF step8 set, otherwise floats.
// - Quick-settle: pin 1 pulls low while IF x8 gain set, otherwise floats.
// - Data shifts in MSB first; strobe rise loads latch named by low bits, except code 11, which loads nothing.
// - Bit 21 picks pump-gated synchronous or immediate power down.
// - Counter-clear bit holds IF main and reference counters in reset.
module sdc_config_latches
(
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_b,
    // Serial link from the host
    input  wire logic        i_link_clk,
    input  wire logic        i_link_data,
    input  wire logic        i_load_strobe,
    // Loop status, on the reference clock
    input  wire logic        i_analog_lock,
    input  wire logic        i_if_digital_lock,
    input  wire logic        i_rf_digital_lock,
    input  wire logic        i_if_ref_div_out,
    input  wire logic        i_if_main_div_out,
    input  wire logic        i_rf_ref_div_out,
    input  wire logic        i_rf_main_div_out,
    input  wire logic        i_if_pump_pulse_done,
    // Shared lock and divider output
    output var  logic        o_shared_out,
    // RF reference-divider settings
    output var  logic [14:0] o_rf_reference_count,
    output var  logic        o_rf_detector_polarity,
    output var  logic [3:0]  o_rf_pump_word,
    output var  logic [10:0] o_rf_pump_ua,
    output var  logic        o_doubler_enable,
    output var  logic        o_dll_fast,
    // IF main-divider settings and the IF reference x8 gain
    output var  logic [2:0]  o_if_swallow_count,
    output var  logic [11:0] o_if_main_count,
    output var  logic        o_spur_comp_enable,
    output var  logic        o_if_pump_x8,
    output var  logic        o_if_main_counter_reset,
    output var  logic        o_if_ref_counter_reset,
    output var  logic        o_powerdown_style,
    output var  logic        o_if_loop_powerdown,
    // General output pins
    output var  logic        o_general_pin0,
    output var  logic        o_general_pin0_oe,
    output var  logic        o_general_pin1,
    output var  logic        o_general_pin1_oe
);
    import sdc_pkg::*;

    logic [`SDC_WORD_W-1:0] shift_reg;
    logic                   strobe_level;
    logic                   strobe_prev_reg;
    logic [`SDC_WORD_W-1:0] rf_reg;
    logic [`SDC_WORD_W-1:0] if_reg;
    logic [2:0]             osel_reg;
    logic                   ifr_x8_reg;
    logic                   spur_reg;
    logic                   shared_reg;
    logic [10:0]            pump_ua_reg;
    logic                   pin0_reg;
    logic                   pin0_oe_reg;
    logic                   pin1_reg;
    logic                   pin1_oe_reg;
    logic                   pdown_reg;
    sdc_pd_state_type       pd_state_reg;
    sdc_pd_state_type       pd_state_next;

    // Link side: host stops its clock while the strobe is high
    always_ff @(posedge i_link_clk)
    begin
        shift_reg <= {shift_reg[`SDC_WORD_W-2:0], i_link_data};
    end

    sdc_pin_sync u_strobe_sync
    (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_pin     (i_load_strobe),
        .o_level   (strobe_level)
    );

    // Word crossing: the shift register is quiet once the strobe has risen,
    // so it is sampled only after the strobe has passed the synchroniser.
    wire           load_fire;
    sdc_latch_type load_sel;
    wire           rf_write;
    wire           if_write;
    wire           ifr_write;

    assign load_fire = strobe_level && !strobe_prev_reg;
    assign load_sel  = sdc_latch_type'(shift_reg[`SDC_SEL_MSB:`SDC_SEL_LSB]);
    assign rf_write  = load_fire && (load_sel == SDC_LATCH_RF_REF);
    assign if_write  = load_fire && (load_sel == SDC_LATCH_IF_MAIN);
    assign ifr_write = load_fire && (load_sel == SDC_LATCH_IF_REF);

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            strobe_prev_reg <= 1'h0;
            rf_reg          <= `SDC_RF_RESET;
            if_reg          <= `SDC_IF_RESET;
            osel_reg        <= `SDC_IFR_OSEL_RESET;
            ifr_x8_reg      <= 1'h0;
            spur_reg        <= `SDC_IF_SPUR_RESET;
        end
        else
        begin
            strobe_prev_reg <= strobe_level;
            if (rf_write)
            begin
                rf_reg <= shift_reg;
            end
            if (if_write)
            begin
                // Kept inverted in its own flop so the output needs no gate
                spur_reg <= !shift_reg[`SDC_IF_TEST_BIT];
                if_reg <= shift_reg;
            end
            if (ifr_write)
            begin
                osel_reg   <= shift_reg[`SDC_IFR_OSEL_MSB:`SDC_IFR_OSEL_LSB];
                ifr_x8_reg <= shift_reg[`SDC_IFR_X8_BIT];
            end
        end
    end

    // Shared output selection
    wire both_digital;
    wire lock_pick;
    wire div_pick;
    wire shared_next;

    assign both_digital = i_if_digital_lock && i_rf_digital_lock;
    assign lock_pick    = osel_reg[1] ? (osel_reg[0] ? both_digital : i_rf_digital_lock)
                                      : (osel_reg[0] ? i_if_digital_lock : i_analog_lock);
    assign div_pick     = osel_reg[1] ? (osel_reg[0] ? i_rf_main_div_out : i_rf_ref_div_out)
                                      : (osel_reg[0] ? i_if_main_div_out : i_if_ref_div_out);
    assign shared_next  = osel_reg[2] ? div_pick : lock_pick;

    // Pump current in uA
    wire [10:0] pump_ua_next;

    assign pump_ua_next = 11'(({7'h0, rf_reg[`SDC_RF_PUMP_MSB:`SDC_RF_PUMP_LSB]} + 11'h1)
                              * `SDC_PUMP_STEP_UA);

    // General pins; in quick-settle mode the level bits do not matter
    wire fast_mode;
    wire pin0_next;
    wire pin0_oe_next;
    wire pin1_next;
    wire pin1_oe_next;

    assign fast_mode    = if_reg[`SDC_IF_FAST_BIT];
    assign pin0_next    = fast_mode ? 1'h0 : if_reg[`SDC_IF_PIN0_BIT];
    assign pin0_oe_next = fast_mode ? rf_reg[`SDC_RF_STEP8_BIT] : 1'h1;
    assign pin1_next    = fast_mode ? 1'h0 : if_reg[`SDC_IF_PIN1_BIT];
    assign pin1_oe_next = fast_mode ? ifr_x8_reg : 1'h1;

    // Power down of the IF loop
    wire pd_req;
    wire pd_style;

    assign pd_req   = if_reg[`SDC_IF_PDOWN_BIT];
    assign pd_style = if_reg[`SDC_IF_STYLE_BIT];

    always_comb
    begin
        pd_state_next = pd_state_reg;
        case (pd_state_reg)
            SDC_PD_ON:
            begin
                if (pd_req)
                begin
                    pd_state_next = pd_style ? SDC_PD_WAIT : SDC_PD_OFF;
                end
            end
            SDC_PD_WAIT:
            begin
                if (!pd_req)
                begin
                    pd_state_next = SDC_PD_ON;
                end
                else if (i_if_pump_pulse_done || !pd_style)
                begin
                    pd_state_next = SDC_PD_OFF;
                end
            end
            SDC_PD_OFF:
            begin
                if (!pd_req)
                begin
                    pd_state_next = SDC_PD_ON;
                end
            end
            default:
            begin
                pd_state_next = SDC_PD_ON;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            shared_reg   <= 1'h0;
            pump_ua_reg  <= `SDC_PUMP_STEP_UA;
            pin0_reg     <= 1'h0;
            pin0_oe_reg  <= 1'h0;
            pin1_reg     <= 1'h0;
            pin1_oe_reg  <= 1'h0;
            pd_state_reg <= SDC_PD_ON;
            pdown_reg    <= 1'h0;
        end
        else
        begin
            shared_reg   <= shared_next;
            pump_ua_reg  <= pump_ua_next;
            pin0_reg     <= pin0_next;
            pin0_oe_reg  <= pin0_oe_next;
            pin1_reg     <= pin1_next;
            pin1_oe_reg  <= pin1_oe_next;
            pd_state_reg <= pd_state_next;
            pdown_reg    <= (pd_state_next == SDC_PD_OFF);
        end
    end

    assign o_shared_out            = shared_reg;
    assign o_rf_reference_count    = rf_reg[`SDC_RF_COUNT_MSB:`SDC_RF_COUNT_LSB];
    assign o_rf_detector_polarity  = rf_reg[`SDC_RF_POL_BIT];
    assign o_rf_pump_word          = rf_reg[`SDC_RF_PUMP_MSB:`SDC_RF_PUMP_LSB];
    assign o_rf_pump_ua            = pump_ua_reg;
    assign o_doubler_enable        = rf_reg[`SDC_RF_DOUBLER_BIT];
    assign o_dll_fast              = rf_reg[`SDC_RF_DLL_BIT];
    assign o_if_swallow_count      = if_reg[`SDC_IF_SWALLOW_MSB:`SDC_IF_SWALLOW_LSB];
    assign o_if_main_count         = if_reg[`SDC_IF_MAIN_MSB:`SDC_IF_MAIN_LSB];
    assign o_spur_comp_enable      = spur_reg;
    assign o_if_pump_x8            = ifr_x8_reg;
    assign o_if_main_counter_reset = if_reg[`SDC_IF_CLEAR_BIT];
    assign o_if_ref_counter_reset  = if_reg[`SDC_IF_CLEAR_BIT];
    assign o_powerdown_style       = pd_style;
    assign o_if_loop_powerdown     = pdown_reg;
    assign o_general_pin0          = pin0_reg;
    assign o_general_pin0_oe       = pin0_oe_reg;
    assign o_general_pin1          = pin1_reg;
    assign o_general_pin1_oe       = pin1_oe_reg;

    // Checks
    default clocking cb_ref @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);

    sequence s_rf_write;
        load_fire && (shift_reg[1:0] == `SDC_SEL_RF_REF);
    endsequence

    sequence s_if_write;
        load_fire && (shift_reg[1:0] == `SDC_SEL_IF_MAIN);
    endsequence

    sequence s_wait_pulse;
        (pd_state_reg == SDC_PD_WAIT) && pd_req && pd_style && i_if_pump_pulse_done;
    endsequence

    a_shared_out_select_both_lock: assert property ((osel_reg == 3'h3) |=>
        (o_shared_out == ($past(i_if_digital_lock) && $past(i_rf_digital_lock))))
        else $error("shared output is not the joint digital lock");

    a_shared_out_select_rf_main: assert property ((osel_reg == 3'h7) |=>
        (o_shared_out == $past(i_rf_main_div_out)))
        else $error("shared output is not the RF main counter");

    a_rf_load_word: assert property (s_rf_write |=> (rf_reg == $past(shift_reg)))
        else $error("RF reference latch missed its load");

    a_rf_hold_other: assert property (!rf_write |=> $stable(rf_reg))
        else $error("RF reference latch changed without its load");

    a_if_load_word: assert property (s_if_write |=> (if_reg == $past(shift_reg)))
        else $error("IF main latch missed its load");

    a_pump_current: assert property (s_rf_write |-> ##2
        (o_rf_pump_ua == 11'(({7'h0, $past(shift_reg[21:18], 2)} + 11'h1) * 11'h064)))
        else $error("pump current does not follow the loaded code");

    a_pin_fast_low: assert property ((fast_mode && rf_reg[21]) |=>
        (o_general_pin0_oe && !o_general_pin0))
        else $error("pin 0 not pulled low in quick-settle");

    a_pin_level_set: assert property (!fast_mode |=>
        (o_general_pin1_oe && (o_general_pin1 == $past(if_reg[18]))))
        else $error("pin 1 level does not follow its bit");

    a_pd_sync_gate: assert property (((pd_state_reg == SDC_PD_ON) && pd_req && pd_style) |=>
        (!o_if_loop_powerdown && (pd_state_reg == SDC_PD_WAIT)))
        else $error("synchronous power down did not wait for the pump");

    a_pd_sync_done: assert property (s_wait_pulse |=> o_if_loop_powerdown)
        else $error("power down missed the pump pulse completion");

    a_pd_async_now: assert property ((pd_req && !pd_style) |=> o_if_loop_powerdown)
        else $error("asynchronous power down was not immediate");

    a_if_hold_other: assert property (!if_write |=> $stable(if_reg))
        else $error("IF main latch changed without its load");

    a_shared_out_select_if_lock: assert property ((osel_reg == 3'h1) |=>
        (o_shared_out == $past(i_if_digital_lock)))
        else $error("shared output is not the IF digital lock");

    a_pin0_fast_float: assert property ((fast_mode && !rf_reg[`SDC_RF_STEP8_BIT]) |=>
        !o_general_pin0_oe)
        else $error("pin 0 not released in quick-settle");

    a_pin1_fast_float: assert property ((fast_mode && !ifr_x8_reg) |=>
        (!o_general_pin1_oe && !o_general_pin1))
        else $error("pin 1 not released in quick-settle");

    a_spur_follow: assert property (s_if_write |=> (o_spur_comp_enable == !$past(shift_reg[19])))
        else $error("spur compensation does not follow the test bit");

endmodule

`default_nettype wire

// file: hw/sdc_cfg.svh
`ifndef SDC_CFG_SVH
`define SDC_CFG_SVH

// Serial word
`define SDC_WORD_W          24
`define SDC_SEL_MSB         1
`define SDC_SEL_LSB         0

// Latch select codes carried in the two lowest bits
`define SDC_SEL_IF_REF      2'h0
`define SDC_SEL_IF_MAIN     2'h1
`define SDC_SEL_RF_REF      2'h2
`define SDC_SEL_RF_MAIN     2'h3

// Reference-divider latch of the RF loop
`define SDC_RF_DLL_BIT      23
`define SDC_RF_DOUBLER_BIT  22
`define SDC_RF_PUMP_MSB     21
`define SDC_RF_PUMP_LSB     18
`define SDC_RF_STEP8_BIT    21
`define SDC_RF_POL_BIT      17
`define SDC_RF_COUNT_MSB    16
`define SDC_RF_COUNT_LSB    2
`define SDC_RF_RESET        24'h000000

// Main-divider latch of the IF loop
`define SDC_IF_CLEAR_BIT    23
`define SDC_IF_PDOWN_BIT    22
`define SDC_IF_STYLE_BIT    21
`define SDC_IF_FAST_BIT     20
`define SDC_IF_TEST_BIT     19
`define SDC_IF_PIN1_BIT     18
`define SDC_IF_PIN0_BIT     17
`define SDC_IF_MAIN_MSB     16
`define SDC_IF_MAIN_LSB     5
`define SDC_IF_SWALLOW_MSB  4
`define SDC_IF_SWALLOW_LSB  2
`define SDC_IF_RESET        24'h000000
`define SDC_IF_SPUR_RESET   1'h1

// Fields kept from the IF reference latch
`define SDC_IFR_OSEL_MSB    21
`define SDC_IFR_OSEL_LSB    19
`define SDC_IFR_X8_BIT      18
`define SDC_IFR_OSEL_RESET  3'h0

// Pump current: 100 uA base plus 100 uA per code unit
`define SDC_PUMP_STEP_UA    11'h064

`endif

// file: hw/sdc_pkg.sv
`include "sdc_cfg.svh"

package sdc_pkg;

    typedef enum logic [1:0]
    {
        SDC_LATCH_IF_REF  = `SDC_SEL_IF_REF,
        SDC_LATCH_IF_MAIN = `SDC_SEL_IF_MAIN,
        SDC_LATCH_RF_REF  = `SDC_SEL_RF_REF,
        SDC_LATCH_RF_MAIN = `SDC_SEL_RF_MAIN
    } sdc_latch_type;

    typedef enum logic [1:0]
    {
        SDC_PD_ON   = 2'h0,
        SDC_PD_WAIT = 2'h1,
        SDC_PD_OFF  = 2'h2
    } sdc_pd_state_type;

endpackage

// file: hw/sdc_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module sdc_pin_sync
(
    // Clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rst_b,
    // Pin and its clean copy
    input  wire logic i_pin,
    output var  logic o_level
);
    logic stage1_reg;
    logic stage2_reg;
    logic stage3_reg;
    logic level_reg;

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            stage1_reg <= 1'h0;
            stage2_reg <= 1'h0;
            stage3_reg <= 1'h0;
            level_reg  <= 1'h0;
        end
        else
        begin
            stage1_reg <= i_pin;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            // A change counts only once two late stages agree
            if (stage2_reg == stage3_reg)
            begin
                level_reg <= stage3_reg;
            end
        end
    end

    assign o_level = level_reg;

endmodule

`default_nettype wire

// file: dv/sdc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module sdc_host_model
(
    // Serial link to the device
    output var logic o_link_clk,
    output var logic o_link_data,
    output var logic o_load_strobe
);

    initial
    begin
        o_link_clk    = 1'b0;
        o_link_data   = 1'b0;
        o_load_strobe = 1'b0;
    end

    // Host keeps the counts in their legal ranges before shifting
    function automatic logic [23:0] legalize(input logic [23:0] w);
        logic [23:0] f;
        f = w;
        if (f[1:0] == 2'h2 && f[16:2] < 15'h0003)
        begin
            f[16:2] = 15'h0003;
        end
        if (f[1:0] == 2'h1 && f[16:5] < 12'h007)
        begin
            f[16:5] = 12'h007;
        end
        return f;
    endfunction

    // Link clock runs only within a frame
    task automatic send_word(input logic [23:0] w);
        #1.3;
        for (int i = 23; i >= 0; i--)
        begin
            o_link_data = w[i];
            #40;
            o_link_clk = 1'b1;
            #40;
            o_link_clk = 1'b0;
        end
        // Released data line must not keep a believable value
        o_link_data = ~w[0];
        #20;
        o_load_strobe = 1'b1;
        #40;
        o_load_strobe = 1'b0;
        #20;
    endtask

endmodule

`default_nettype wire

// file: dv/synth_divider_config_latches_test.sv
`timescale 1ns/1ps
`default_nettype none

module synth_divider_config_latches_test;
    import sdc_pkg::*;

    typedef struct {string name; logic [23:0] exp;} sdc_note_type;

    logic         clk;
    logic         rst_b;
    logic         link_clk, link_data, strobe;
    logic         alock, ifdl, rfdl, ifrd, ifmd, rfrd, rfmd, pdone;
    logic         shared, rf_pol, dbl, dll, spur, x8, mrst, rrst, style, pdown;
    logic         pin0, oe0, pin1, oe1;
    logic [14:0]  rf_cnt;
    logic [3:0]   rf_pump;
    logic [10:0]  pump_ua;
    logic [2:0]   swal;
    logic [11:0]  mcnt;
    sdc_note_type q[$];
    event         check_ev;
    int           err_count = 0;
    int           cmp_count = 0;
    int           cycles = 0;
    int           seed;
    logic [23:0]  rf_m, ifn_m, w;
    logic [2:0]   osel_m;
    logic         x8_m, pd_m;
    logic         exp_bit;

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    sdc_host_model u_sdc_host_model
    (
        .o_link_clk    (link_clk),
        .o_link_data   (link_data),
        .o_load_strobe (strobe)
    );

    sdc_config_latches u_sdc_config_latches
    (
        .i_ref_clk (clk), .i_rst_b (rst_b),
        .i_link_clk (link_clk), .i_link_data (link_data), .i_load_strobe (strobe),
        .i_analog_lock (alock), .i_if_digital_lock (ifdl), .i_rf_digital_lock (rfdl),
        .i_if_ref_div_out (ifrd), .i_if_main_div_out (ifmd),
        .i_rf_ref_div_out (rfrd), .i_rf_main_div_out (rfmd),
        .i_if_pump_pulse_done (pdone), .o_shared_out (shared),
        .o_rf_reference_count (rf_cnt), .o_rf_detector_polarity (rf_pol),
        .o_rf_pump_word (rf_pump), .o_rf_pump_ua (pump_ua),
        .o_doubler_enable (dbl), .o_dll_fast (dll),
        .o_if_swallow_count (swal), .o_if_main_count (mcnt),
        .o_spur_comp_enable (spur), .o_if_pump_x8 (x8),
        .o_if_main_counter_reset (mrst), .o_if_ref_counter_reset (rrst),
        .o_powerdown_style (style), .o_if_loop_powerdown (pdown),
        .o_general_pin0 (pin0), .o_general_pin0_oe (oe0),
        .o_general_pin1 (pin1), .o_general_pin1_oe (oe1)
    );

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
        begin
            $display("Result: passed");
        end
        else
        begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            err_count = err_count + 1;
            complete_run();
        end
    end

    task automatic compare_val(input string name, input logic [23:0] exp, input logic [23:0] got);
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic [23:0] seen(input string name);
        case (name)
            "rf_count":  return {9'h0, rf_cnt};
            "rf_pol":    return {23'h0, rf_pol};
            "rf_pump":   return {20'h0, rf_pump};
            "pump_ua":   return {13'h0, pump_ua};
            "doubler":   return {23'h0, dbl};
            "dll":       return {23'h0, dll};
            "swallow":   return {21'h0, swal};
            "main":      return {12'h0, mcnt};
            "spur":      return {23'h0, spur};
            "x8":        return {23'h0, x8};
            "ctr_reset": return {22'h0, mrst, rrst};
            "style":     return {23'h0, style};
            "powerdown": return {23'h0, pdown};
            "pin0":      return {22'h0, pin0, oe0};
            "pin1":      return {22'h0, pin1, oe1};
            default:     return {23'h0, shared};
        endcase
    endfunction

    // Every queued note, oldest first, is matched against the outputs when a check fires
    initial
    begin
        sdc_note_type n;
        forever
        begin
            @(check_ev);
            while (q.size() > 0)
            begin
                n = q.pop_front();
                compare_val(n.name, n.exp, seen(n.name));
            end
        end
    end

    task automatic note(input string name, input logic [23:0] exp);
        q.push_back('{name, exp});
    endtask

    task automatic expect_all();
        logic fast;
        fast = ifn_m[20];
        note("rf_count", {9'h0, rf_m[16:2]});
        note("rf_pol", {23'h0, rf_m[17]});
        note("rf_pump", {20'h0, rf_m[21:18]});
        note("pump_ua", ({20'h0, rf_m[21:18]} + 24'h1) * 24'h64);
        note("doubler", {23'h0, rf_m[22]});
        note("dll", {23'h0, rf_m[23]});
        note("swallow", {21'h0, ifn_m[4:2]});
        note("main", {12'h0, ifn_m[16:5]});
        note("spur", {23'h0, ~ifn_m[19]});
        note("x8", {23'h0, x8_m});
        note("ctr_reset", {22'h0, ifn_m[23], ifn_m[23]});
        note("style", {23'h0, ifn_m[21]});
        note("powerdown", {23'h0, pd_m});
        note("pin0", {22'h0, fast ? 1'b0 : ifn_m[17], fast ? rf_m[21] : 1'b1});
        note("pin1", {22'h0, fast ? 1'b0 : ifn_m[18], fast ? x8_m : 1'b1});
        -> check_ev;
    endtask

    task automatic wr(input logic [23:0] word);
        logic [23:0] f;
        f = u_sdc_host_model.legalize(word);
        case (f[1:0])
            SDC_LATCH_RF_REF:  rf_m = f;
            SDC_LATCH_IF_REF:  {osel_m, x8_m} = f[21:18];
            SDC_LATCH_IF_MAIN:
            begin
                ifn_m = f;
                if (!f[22]) pd_m = 1'b0;
                else if (!f[21]) pd_m = 1'b1;
            end
            default:           ;
        endcase
        u_sdc_host_model.send_word(f);
        @(negedge clk);
        expect_all();
    endtask

    function automatic logic pick(input logic [2:0] s);
        logic [3:0] lk, dv;
        lk = {ifdl & rfdl, rfdl, ifdl, alock};
        dv = {rfmd, rfrd, ifmd, ifrd};
        return s[2] ? dv[s[1:0]] : lk[s[1:0]];
    endfunction

    initial
    begin
        seed = 59913;
        rst_b = 1'b0;
        {alock, ifdl, rfdl, ifrd, ifmd, rfrd, rfmd, pdone} = 8'h00;
        {rf_m, ifn_m, osel_m, x8_m, pd_m} = '0;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        expect_all();
        for (int c = 0; c < 16; c++)
        begin
            w = 24'($random(seed));
            w[21:18] = c[3:0];
            w[1:0] = SDC_LATCH_RF_REF;
            wr(w);
        end
        wr(24'h01fffe);
        wr(24'h000002);
        for (int i = 0; i < 6; i++)
        begin
            w = 24'($random(seed));
            w[20] = i[0];
            w[1:0] = SDC_LATCH_IF_MAIN;
            wr(w);
            w[1:0] = SDC_LATCH_RF_MAIN;
            wr(w);
            w[1:0] = SDC_LATCH_IF_REF;
            wr(w);
        end
        for (int s = 0; s < 8; s++)
        begin
            w = 24'($random(seed));
            w[21:19] = s[2:0];
            w[1:0] = SDC_LATCH_IF_REF;
            wr(w);
            repeat (4)
            begin
                {alock, ifdl, rfdl, ifrd, ifmd, rfrd, rfmd} = 7'($random(seed));
                exp_bit = pick(s[2:0]);
                // Noted only after the edge, so the drain never sees it early
                @(negedge clk);
                note("shared", {23'h0, exp_bit});
                -> check_ev;
            end
        end
        wr(24'h000001);
        wr(24'h600001);
        pdone = 1'b1;
        @(negedge clk);
        pdone = 1'b0;
        pd_m = 1'b1;
        @(negedge clk);
        expect_all();
        wr(24'h000001);
        wr(24'h400001);
        wr(24'h800001);
        // Let the checker drain the last notes before the verdict
        @(negedge clk);
        complete_run();
    end

endmodule

`default_nettype wire
